// ---- src/rrsf_consts.vh ----
// Constants for the rotate-right / fill-ones execution block
`ifndef RRSF_CONSTS_VH
`define RRSF_CONSTS_VH
// Opcode matching: upper bits of the 16-bit instruction word
`define RRSF_ROT_OPC 6'h10
`define RRSF_ROT_OPC_HI 15
`define RRSF_ROT_OPC_LO 10
`define RRSF_FILL_OPC 7'h34
`define RRSF_FILL_OPC_HI 15
`define RRSF_FILL_OPC_LO 9
// Field positions
`define RRSF_DEST_BIT 9
`define RRSF_BANKSEL_BIT 8
`define RRSF_FADDR_HI 7
`define RRSF_FADDR_LO 0
// Status register bit positions
`define RRSF_ST_ZERO 2
`define RRSF_ST_MSB 4
// Indexed literal offset limit (95)
`define RRSF_IDX_LIMIT 8'h5f
// Fixed window: low half below split, high half mapped to bank 15
`define RRSF_WIN_SPLIT 8'h80
`define RRSF_WIN_HI_BANK 4'hf
`define RRSF_FILL_VALUE 8'hff
// Register bus offsets
`define RRSF_REG_INSTR 4'h0
`define RRSF_REG_ACC 4'h1
`define RRSF_REG_STATUS 4'h2
`define RRSF_REG_BANK 4'h3
`define RRSF_REG_CTRL 4'h4
`define RRSF_REG_PHASE 4'h5
`define RRSF_REG_INDEX 4'h6
`define RRSF_REG_LAST_ADDR 4'h7
`define RRSF_CTRL_EXT_BIT 0
// Reset values
`define RRSF_RST_ACC 8'h00
`define RRSF_RST_STATUS 8'h00
`define RRSF_RST_BANK 4'h0
`define RRSF_RST_INSTR 16'h0000
`endif

// ---- src/rrsf_addr_gen.v ----
// Operand address generator for the two byte-oriented instructions
`include "rrsf_consts.vh"
module rrsf_addr_gen (
    input wire [7:0] faddr,
    input wire bank_sel,
    input wire ext_en,
    input wire [3:0] bank_pointer,
    input wire [11:0] index_base,
    output reg [11:0] data_addr,
    output reg indexed
);
    always @* begin
        indexed = 1'b0;
        if (bank_sel) begin
            data_addr = {bank_pointer, faddr};
        end else if (ext_en && faddr <= `RRSF_IDX_LIMIT) begin
            // Offset sum wraps within the 12-bit data space
            data_addr = index_base + {4'h0, faddr};
            indexed = 1'b1;
        end else if (faddr < `RRSF_WIN_SPLIT) begin
            data_addr = {4'h0, faddr};
        end else begin
            data_addr = {`RRSF_WIN_HI_BANK, faddr};
        end
    end
endmodule // rrsf_addr_gen

// ---- src/rrsf_exec.v ----
// Four-phase execution core for rotate-right-plain and fill-ones
//
// Our own choices: the register offsets and strobed register access.
`include "rrsf_consts.vh"
module rrsf_exec #(
    parameter AW = 12
) (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire instr_valid,
    input wire [15:0] instr_word,
    output wire instr_ready,
    output reg [AW-1:0] mem_addr,
    output reg mem_rd,
    input wire [7:0] mem_rdata,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    output reg done,
    output reg illegal
);
    localparam [3:0] PH_DECODE = 4'b0001;
    localparam [3:0] PH_READ = 4'b0010;
    localparam [3:0] PH_PROC = 4'b0100;
    localparam [3:0] PH_WRITE = 4'b1000;
    localparam [3:0] PH_IDLE = 4'b0000;

    reg [3:0] phase_q;
    reg [15:0] instr_q;
    reg [7:0] acc_q;
    reg [7:0] status_q;
    reg [3:0] bank_q;
    reg ext_q;
    reg [11:0] index_q;
    reg [AW-1:0] last_addr_q;
    reg [7:0] result_q;
    reg is_rot_q;
    reg is_fill_q;

    wire [11:0] gen_addr;
    wire gen_indexed;

    function [7:0] rot_right;
        input [7:0] v;
        begin
            rot_right = {v[0], v[7:1]};
        end
    endfunction

    function is_rot;
        input [15:0] w;
        begin
            is_rot = (w[`RRSF_ROT_OPC_HI:`RRSF_ROT_OPC_LO] == `RRSF_ROT_OPC);
        end
    endfunction

    function is_fill;
        input [15:0] w;
        begin
            is_fill = (w[`RRSF_FILL_OPC_HI:`RRSF_FILL_OPC_LO] == `RRSF_FILL_OPC);
        end
    endfunction

    rrsf_addr_gen u_addr (
        .faddr(instr_q[`RRSF_FADDR_HI:`RRSF_FADDR_LO]),
        .bank_sel(instr_q[`RRSF_BANKSEL_BIT]),
        .ext_en(ext_q),
        .bank_pointer(bank_q),
        .index_base(index_q),
        .data_addr(gen_addr),
        .indexed(gen_indexed)
    );

    // New word taken only while idle and enabled
    assign instr_ready = ce && (phase_q == PH_IDLE);

    wire dest_mem = instr_q[`RRSF_DEST_BIT];
    wire take = instr_valid && instr_ready;
    wire sw_wr_ok = reg_wr && (phase_q == PH_IDLE);

    // Instruction sequencer
    always @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= PH_IDLE;
            instr_q <= `RRSF_RST_INSTR;
            is_rot_q <= 1'b0;
            is_fill_q <= 1'b0;
            result_q <= 8'h00;
            last_addr_q <= {AW{1'b0}};
            mem_addr <= {AW{1'b0}};
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            done <= 1'b0;
            illegal <= 1'b0;
        end else if (ce) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            case (phase_q)
                PH_IDLE: begin
                    if (take) begin
                        instr_q <= instr_word;
                        phase_q <= PH_DECODE;
                    end
                end
                PH_DECODE: begin
                    is_rot_q <= is_rot(instr_q);
                    is_fill_q <= is_fill(instr_q);
                    mem_addr <= gen_addr[AW-1:0];
                    last_addr_q <= gen_addr[AW-1:0];
                    mem_rd <= is_rot(instr_q);
                    if (is_rot(instr_q) || is_fill(instr_q)) begin
                        phase_q <= PH_READ;
                    end else begin
                        // Unknown opcode: flagged and dropped; acc and status untouched, but last_addr_q and mem_addr still take the decoded address
                        illegal <= 1'b1;
                        phase_q <= PH_IDLE;
                    end
                end
                PH_READ: begin
                    // Read strobe is out; synchronous memory answers next cycle
                    phase_q <= PH_PROC;
                end
                PH_PROC: begin
                    // Operand taken straight off the bus, saves a holding register
                    if (is_rot_q) begin
                        result_q <= rot_right(mem_rdata);
                    end else begin
                        result_q <= `RRSF_FILL_VALUE;
                    end
                    phase_q <= PH_WRITE;
                end
                PH_WRITE: begin
                    if (is_fill_q || dest_mem) begin
                        mem_wr <= 1'b1;
                        mem_wdata <= result_q;
                    end
                    done <= 1'b1;
                    phase_q <= PH_IDLE;
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

    // Architectural state: accumulator, status, bank pointer, control
    always @(posedge ref_clk) begin
        if (rst) begin
            acc_q <= `RRSF_RST_ACC;
            status_q <= `RRSF_RST_STATUS;
            bank_q <= `RRSF_RST_BANK;
            ext_q <= 1'b0;
            index_q <= 12'h000;
        end else if (ce) begin
            if (phase_q == PH_WRITE && is_rot_q) begin
                if (!dest_mem) begin
                    acc_q <= result_q;
                end
                status_q[`RRSF_ST_MSB] <= result_q[7];
                status_q[`RRSF_ST_ZERO] <= (result_q == 8'h00);
            end else if (sw_wr_ok) begin
                // Software writes only land between instructions
                case (reg_addr)
                    `RRSF_REG_ACC: acc_q <= reg_wdata[7:0];
                    `RRSF_REG_STATUS: status_q <= reg_wdata[7:0];
                    `RRSF_REG_BANK: bank_q <= reg_wdata[3:0];
                    `RRSF_REG_CTRL: ext_q <= reg_wdata[`RRSF_CTRL_EXT_BIT];
                    `RRSF_REG_INDEX: index_q <= reg_wdata[11:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data one cycle after the strobe
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `RRSF_REG_INSTR: reg_rdata <= instr_q;
                    `RRSF_REG_ACC: reg_rdata <= {8'h00, acc_q};
                    `RRSF_REG_STATUS: reg_rdata <= {8'h00, status_q};
                    `RRSF_REG_BANK: reg_rdata <= {12'h000, bank_q};
                    `RRSF_REG_CTRL: reg_rdata <= {15'h0000, ext_q};
                    `RRSF_REG_PHASE: reg_rdata <= {11'h000, gen_indexed, phase_q};
                    `RRSF_REG_INDEX: reg_rdata <= {4'h0, index_q};
                    `RRSF_REG_LAST_ADDR: reg_rdata <= {{(16-AW){1'b0}}, last_addr_q};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // rrsf_exec

// ---- tb/rrsf_checker.sv ----
// Assertions on the ports of the execution block
module rrsf_checker #(parameter AW = 12) (
    input logic ref_clk,
    input logic rst,
    input logic ce,
    input logic [3:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_wr,
    input logic instr_valid,
    input logic [15:0] instr_word,
    input logic instr_ready,
    input logic [AW-1:0] mem_addr,
    input logic mem_rd,
    input logic [7:0] mem_rdata,
    input logic mem_wr,
    input logic [7:0] mem_wdata,
    input logic done,
    input logic illegal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] bank_q;
    logic ext_q;
    logic [11:0] idx_q;
    logic [7:0] op_q;
    logic rd_q;
    wire take = instr_valid && instr_ready;
    wire rot = take && instr_word[15:10] == 6'h10;
    wire fill = take && instr_word[15:9] == 7'h34;
    wire [7:0] f = instr_word[7:0];
    // Shadow of software state; writes only land while idle
    always @(posedge ref_clk) begin
        rd_q <= mem_rd;
        if (rd_q) op_q <= mem_rdata;
        if (rst) begin
            bank_q <= 4'h0;
            ext_q <= 1'b0;
            idx_q <= 12'h000;
        end else if (reg_wr && instr_ready) begin
            if (reg_addr == 4'h3) bank_q <= reg_wdata[3:0];
            if (reg_addr == 4'h4) ext_q <= reg_wdata[0];
            if (reg_addr == 4'h6) idx_q <= reg_wdata[11:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);
    a_take_to_done: assert property ((rot || fill) |=> !instr_ready [*4] ##1 done)
        else $error("done not five cycles after take");
    a_rot_reads: assert property (rot |=> ##1 mem_rd)
        else $error("rotate did not read operand");
    a_fill_ones: assert property (fill |=> !mem_rd [*4] ##1 (mem_wr && mem_wdata == 8'hff))
        else $error("fill did not write ones");
    a_rot_value: assert property (mem_wr && $past(mem_rd, 3) |-> mem_wdata == {op_q[0], op_q[7:1]})
        else $error("rotated value wrong");
    a_acc_target: assert property (rot && !instr_word[9] |=> ##4 (done && !mem_wr))
        else $error("accumulator target wrote memory");
    a_mem_target: assert property (rot && instr_word[9] |=> ##4 mem_wr)
        else $error("memory target not written");
    a_bank_addr: assert property ((rot || fill) && instr_word[8] |=> ##1 mem_addr == {bank_q, $past(f, 2)})
        else $error("banked address wrong");
    a_window_low: assert property ((rot || fill) && !instr_word[8] && f > 8'h5f && f < 8'h80
        |=> ##1 mem_addr == $past(f, 2))
        else $error("window address wrong");
    a_indexed: assert property ((rot || fill) && !instr_word[8] && ext_q && f <= 8'h5f
        |=> ##1 mem_addr == idx_q + $past(f, 2))
        else $error("indexed address wrong");
    a_illegal_op: assert property (take && !rot && !fill |=> ##1 (illegal && !done))
        else $error("illegal opcode not flagged");
    cover property (rot && instr_word[9]);
    cover property (fill);
    cover property ((rot || fill) && !instr_word[8] && ext_q && f <= 8'h5f);
endmodule // rrsf_checker

// ---- tb/rotate_right_and_set_file_exec_bench.sv ----
// Self-checking bench for the execution block
module rotate_right_and_set_file_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, instr_valid = 0, rd_q = 0;
    logic [3:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, instr_word = 0;
    logic [7:0] mem_rdata = 0;
    wire [15:0] reg_rdata;
    wire instr_ready, mem_rd, mem_wr, done, illegal;
    wire [11:0] mem_addr;
    wire [7:0] mem_wdata;
    integer seed = 32'ha79e, n_mismatch = 0, num_checks = 0, i, e, k;
    logic [7:0] mem [0:4095];
    logic [19:0] qm[$];
    logic [15:0] qr[$];
    logic [7:0] v, f, s, r;
    logic [3:0] b;
    logic [11:0] ix, ad;
    rrsf_exec #(.AW(12)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .done(done), .illegal(illegal));
    initial forever #2.5 ref_clk = ~ref_clk;
    task cmp(input string n, input [19:0] x, input [19:0] g);
        num_checks++;
        if (x !== g) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge ref_clk) reg_wr <= 0;
    endtask
    task rd(input [3:0] a, input [15:0] x);
        qr.push_back(x);
        @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk) reg_rd <= 0;
    endtask
    task op(input [15:0] w);
        @(posedge ref_clk) {instr_word, instr_valid} <= {w, 1'b1};
        @(posedge ref_clk) instr_valid <= 0;
        for (k = 0; k < 20 && !(done || illegal); k++) @(negedge ref_clk);
        cmp("completion", 1, k < 20);
    endtask
    // Undriven read data toggles so stale bytes never look valid
    always @(posedge ref_clk) begin
        rd_q <= reg_rd;
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        if (rd_q) cmp("reg_rdata", qr.pop_front(), reg_rdata);
        if (mem_wr) mem[mem_addr] <= mem_wdata;
        if (mem_wr) cmp("mem write", qm.pop_front(), {mem_addr, mem_wdata});
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        // Frozen block must drop a write made while the enable is low
        @(posedge ref_clk) ce <= 0;
        wr(4'h1, 16'h00aa);
        @(posedge ref_clk) ce <= 1;
        rd(4'h1, 16'h0000);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'hf, 16'h0000);
        for (e = 0; e < 2; e++) begin
            b = $random(seed);
            ix = $random(seed);
            wr(4'h3, b);
            wr(4'h4, e);
            wr(4'h6, ix);
            rd(4'h3, b);
            for (i = 0; i < 16; i++) begin
                r = $random(seed);
                v = (i < 2) ? i : $random(seed);
                s = $random(seed);
                f = r[7] ? $random(seed) : $random(seed) & 8'h5f;
                ad = r[1] ? {b, f} : (e && f <= 8'h5f) ? ix + f : f < 8'h80 ? {4'h0, f} : {4'hf, f};
                mem[ad] = v;
                wr(4'h2, s);
                if (r[2] && i > 1) begin
                    qm.push_back({ad, 8'hff});
                    op({7'h34, r[1], f});
                    rd(4'h2, s);
                end else begin
                    v = {v[0], v[7:1]};
                    if (r[0]) qm.push_back({ad, v});
                    op({6'h10, r[0], r[1], f});
                    rd(4'h2, {s[7:5], v[7], s[3], v == 8'h00, s[1:0]});
                    if (!r[0]) rd(4'h1, v);
                end
                rd(4'h7, ad);
            end
        end
        op(16'h0003);
        finish_test;
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
endmodule // rotate_right_and_set_file_exec_bench
bind rrsf_exec rrsf_checker #(.AW(AW)) i_chk (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .done(done), .illegal(illegal));
